// [verilog/interrupt_and_event_transfer_system.sv]
// Interrupt nodes, transfer engine, request router and trap logic.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "intr_cfg.svh"
module interrupt_and_event_transfer_system #(
  parameter int NODES = 96,
  parameter int CHANS = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [87:0] periph_req,
  input wire logic [7:0] shared_src,
  input wire logic [3:0] router_in,
  input wire logic [5:0] hw_trap,
  input wire logic [2:0] service_request_pins,
  input wire logic sw_trap,
  input wire logic [6:0] sw_trap_num,
  input wire logic jump_cache,
  input wire logic trap_done,
  output intr_pkg::entry_type int_entry,
  output intr_pkg::xfer_type xfer,
  output logic trap_entry,
  output logic [2:0] trap_number
);
  logic [9:0] node_reg [NODES];
  logic [11:0] chan_reg [CHANS];
  logic [15:0] src_reg [CHANS];
  logic [15:0] dst_reg [CHANS];
  logic [7:0] trap_flag_reg;
  logic [7:0] trap_seen_reg;
  logic trap_active_reg;
  logic [2:0] trap_level_reg;
  logic [3:0] shsel_reg;
  logic [7:0] edge_reg;
  logic [12:0] gate_reg;
  logic [3:0] rt_prev_reg;
  logic [2:0] srp_prev_reg;
  intr_pkg::state_type state_reg;
  logic [3:0] wait_reg;
  intr_pkg::entry_type entry_reg;
  intr_pkg::xfer_type xfer_reg;
  logic [15:0] rdata_reg;
  logic tentry_reg;
  logic [2:0] tnum_reg;
  logic [NODES-1:0] node_set;
  logic [3:0] rt_ev;
  logic [3:0] rt_out;
  logic win_ok;
  logic [6:0] win_idx;
  logic [3:0] win_pri;
  logic [2:0] win_ch;
  logic [7:0] win_cnt;
  logic trap_new;
  logic [2:0] trap_idx;
  logic [7:0] trap_set;
  logic go;
  logic go_xfer;
  logic go_int;

  // True when the address selects a node control register.
  function automatic logic is_node(input logic [7:0] a);
    is_node = (a <= `A_NODE_LAST);
  endfunction

  // True when the address selects a register of the given eight-block.
  function automatic logic in_block(input logic [7:0] a,
                                    input logic [7:0] base);
    in_block = (a[7:3] == base[7:3]);
  endfunction

  // Edge detection per router input, mode 01 rise, 10 fall, 11 both.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_rt
      assign rt_ev[g] = (edge_reg[2*g] & router_in[g] & ~rt_prev_reg[g]) |
        (edge_reg[2*g+1] & ~router_in[g] & rt_prev_reg[g]);
      // Matrix picks an input event, gate passes it on match or on miss.
      assign rt_out[g] = rt_ev[gate_reg[2*g +: 2]] &
        ((router_in == gate_reg[`G_PAT]) ^ gate_reg[`G_MISS]);
    end
  endgenerate

  // Collect the hardware and software set requests of every node.
  always_comb begin
    node_set = '0;
    node_set[87:0] = periph_req;
    node_set[91:88] = rt_out;
    for (int i = 0; i < 4; i++) begin
      node_set[92+i] = shared_src[2*i + int'(shsel_reg[i])];
    end
    if (sw_trap && sw_trap_num < 7'(NODES)) begin
      node_set[sw_trap_num] = 1'b1;
    end
  end

  // Highest priority enabled pending node; ties go to the lower index.
  always_comb begin
    win_ok = 1'b0;
    win_idx = 7'h00;
    win_pri = 4'h0;
    for (int i = 0; i < NODES; i++) begin
      if (node_reg[i][`N_REQ] && node_reg[i][`N_EN] &&
          (!win_ok || node_reg[i][`N_PRI] > win_pri)) begin
        win_ok = 1'b1;
        win_idx = 7'(i);
        win_pri = node_reg[i][`N_PRI];
      end
    end
  end

  assign win_ch = node_reg[win_idx][`N_CH];
  assign win_cnt = chan_reg[win_ch][`C_CNT];
  // A running or waiting trap holds off interrupts and transfers.
  assign go = (state_reg == intr_pkg::S_IDLE) && win_ok &&
    !trap_active_reg && !trap_new;
  assign go_xfer = go && node_reg[win_idx][`N_XFER] &&
    win_cnt != 8'h00;
  assign go_int = go && !go_xfer;

  // Node registers: hardware set wins over software clear and grant.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NODES; i++) begin
        node_reg[i] <= `RESET_NODE;
      end
    end else if (ce) begin
      for (int i = 0; i < NODES; i++) begin
        if (wr && is_node(addr) && addr[6:0] == 7'(i)) begin
          node_reg[i] <= wdata[9:0] | {9'h000, node_set[i]};
        end else if (go && win_idx == 7'(i)) begin
          node_reg[i][`N_REQ] <= node_set[i];
        end else if (node_set[i]) begin
          node_reg[i][`N_REQ] <= 1'b1;
        end
      end
    end
  end

  // Channel counters and pointers; hardware update beats a write.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int c = 0; c < CHANS; c++) begin
        chan_reg[c] <= 12'h000;
        src_reg[c] <= 16'h0000;
        dst_reg[c] <= 16'h0000;
      end
    end else if (ce) begin
      for (int c = 0; c < CHANS; c++) begin
        if (go_xfer && win_ch == 3'(c)) begin
          if (!chan_reg[c][`C_CONT]) begin
            chan_reg[c][`C_CNT] <= win_cnt - 8'h01;
          end
          if (chan_reg[c][`C_INCS]) begin
            src_reg[c] <= src_reg[c] +
              (chan_reg[c][`C_WORD] ? 16'h0002 : 16'h0001);
          end
          if (chan_reg[c][`C_INCD]) begin
            dst_reg[c] <= dst_reg[c] +
              (chan_reg[c][`C_WORD] ? 16'h0002 : 16'h0001);
          end
        end else if (wr) begin
          if (addr == `A_CNT + 8'(c)) chan_reg[c] <= wdata[11:0];
          if (addr == `A_SRC + 8'(c)) src_reg[c] <= wdata;
          if (addr == `A_DST + 8'(c)) dst_reg[c] <= wdata;
        end
      end
    end
  end

  // Sequencer: one stolen cycle per transfer, fixed latency per interrupt.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= intr_pkg::S_IDLE;
      wait_reg <= 4'h0;
      entry_reg <= '0;
      xfer_reg <= '0;
    end else if (ce) begin
      entry_reg.entry <= 1'b0;
      xfer_reg.valid <= 1'b0;
      unique case (state_reg)
        intr_pkg::S_IDLE: begin
          if (go_xfer) begin
            state_reg <= intr_pkg::S_XFER;
            xfer_reg <= {1'b1, chan_reg[win_ch][`C_WORD], win_ch,
              src_reg[win_ch], dst_reg[win_ch]};
          end else if (go_int) begin
            state_reg <= intr_pkg::S_WAIT;
            entry_reg.vector <= win_idx;
            wait_reg <= jump_cache ? 4'(`RESP_CACHED - 1) :
              4'(`RESP_PLAIN - 1);
          end
        end
        intr_pkg::S_WAIT: begin
          wait_reg <= wait_reg - 4'h1;
          if (wait_reg == 4'h1) begin
            entry_reg.entry <= 1'b1;
            state_reg <= intr_pkg::S_IDLE;
          end
        end
        intr_pkg::S_XFER: begin
          state_reg <= intr_pkg::S_IDLE;
        end
        default: begin
          state_reg <= intr_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Lowest flag index is the highest trap priority.
  always_comb begin
    trap_new = 1'b0;
    trap_idx = 3'h0;
    for (int t = 7; t >= 0; t--) begin
      if (trap_flag_reg[t] && !trap_seen_reg[t]) begin
        trap_new = 1'b1;
        trap_idx = 3'(t);
      end
    end
  end

  // Rising pin edges raise the system requests; pins 1 and 2 share one.
  assign trap_set[7:2] = hw_trap;
  assign trap_set[`TRAP_SR0] = service_request_pins[0] & ~srp_prev_reg[0];
  assign trap_set[`TRAP_SR1] =
    |(service_request_pins[2:1] & ~srp_prev_reg[2:1]);

  // Trap flags: write one to clear, and a new event wins over the clear.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      trap_flag_reg <= 8'h00;
      trap_seen_reg <= 8'h00;
      srp_prev_reg <= 3'h0;
    end else if (ce) begin
      srp_prev_reg <= service_request_pins;
      if (wr && addr == `A_TRAP) begin
        trap_flag_reg <= (trap_flag_reg & ~wdata[7:0]) | trap_set;
        trap_seen_reg <= trap_seen_reg & ~wdata[7:0];
      end else begin
        trap_flag_reg <= trap_flag_reg | trap_set;
      end
      if (trap_new && (!trap_active_reg || trap_idx < trap_level_reg)) begin
        trap_seen_reg[trap_idx] <= 1'b1;
      end
    end
  end

  // Trap entry preempts all but a higher priority trap in service.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      trap_active_reg <= 1'b0;
      trap_level_reg <= 3'h0;
      tentry_reg <= 1'b0;
      tnum_reg <= 3'h0;
    end else if (ce) begin
      tentry_reg <= 1'b0;
      if (trap_new && (!trap_active_reg || trap_idx < trap_level_reg)) begin
        trap_active_reg <= 1'b1;
        trap_level_reg <= trap_idx;
        tentry_reg <= 1'b1;
        tnum_reg <= trap_idx;
      end else if (trap_done) begin
        trap_active_reg <= 1'b0;
      end
    end
  end

  // Router and shared node configuration plus edge history.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      shsel_reg <= 4'h0;
      edge_reg <= 8'h00;
      gate_reg <= 13'h0000;
      rt_prev_reg <= 4'h0;
    end else if (ce) begin
      rt_prev_reg <= router_in;
      if (wr && addr == `A_SHSEL) shsel_reg <= wdata[3:0];
      if (wr && addr == `A_RT_EDGE) edge_reg <= wdata[7:0];
      if (wr && addr == `A_RT_GATE) gate_reg <= wdata[12:0];
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 16'h0000;
    end else if (ce) begin
      rdata_reg <= 16'h0000;
      if (rd) begin
        if (is_node(addr)) rdata_reg <= {6'h00, node_reg[addr[6:0]]};
        else if (in_block(addr, `A_CNT))
          rdata_reg <= {4'h0, chan_reg[addr[2:0]]};
        else if (in_block(addr, `A_SRC)) rdata_reg <= src_reg[addr[2:0]];
        else if (in_block(addr, `A_DST)) rdata_reg <= dst_reg[addr[2:0]];
        else if (addr == `A_TRAP) rdata_reg <= {8'h00, trap_flag_reg};
        else if (addr == `A_SHSEL) rdata_reg <= {12'h000, shsel_reg};
        else if (addr == `A_RT_EDGE) rdata_reg <= {8'h00, edge_reg};
        else if (addr == `A_RT_GATE) rdata_reg <= {3'h0, gate_reg};
        else if (addr == `A_STAT)
          rdata_reg <= {10'h000, state_reg, trap_active_reg,
            trap_level_reg};
      end
    end
  end

  assign rdata = rdata_reg;
  assign int_entry = entry_reg;
  assign xfer = xfer_reg;
  assign trap_entry = tentry_reg;
  assign trap_number = tnum_reg;

  // Checks hold only while the block runs; a frozen cycle voids them.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n || !ce);

  property p_steal_one;
    xfer_reg.valid |=> !xfer_reg.valid && state_reg == intr_pkg::S_IDLE;
  endproperty
  a_steal_one: assert property (p_steal_one)
    else $error("Transfer held the CPU for more than one cycle.");

  property p_resp_cached;
    go_int && jump_cache |=> !int_entry.entry [*6] ##1 int_entry.entry;
  endproperty
  a_resp_cached: assert property (p_resp_cached)
    else $error("Cached interrupt entry not after 7 clocks.");

  property p_resp_plain;
    go_int && !jump_cache |-> ##11 int_entry.entry;
  endproperty
  a_resp_plain: assert property (p_resp_plain)
    else $error("Uncached interrupt entry not after 11 clocks.");

  property p_count_dec;
    go_xfer && !chan_reg[win_ch][`C_CONT] |=>
      chan_reg[$past(win_ch)][`C_CNT] == $past(win_cnt) - 8'h01;
  endproperty
  a_count_dec: assert property (p_count_dec)
    else $error("Transfer counter did not decrement.");

  property p_count_hold;
    go_xfer && chan_reg[win_ch][`C_CONT] |=>
      chan_reg[$past(win_ch)][`C_CNT] == $past(win_cnt);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("Continuous counter changed.");

  property p_zero_vector;
    go && node_reg[win_idx][`N_XFER] && win_cnt == 8'h00 |=>
      state_reg == intr_pkg::S_WAIT && !xfer_reg.valid;
  endproperty
  a_zero_vector: assert property (p_zero_vector)
    else $error("Exhausted channel did not raise an interrupt.");

  property p_trap_block;
    trap_active_reg |=> !xfer_reg.valid;
  endproperty
  a_trap_block: assert property (p_trap_block)
    else $error("Transfer ran during a trap service.");

  property p_trap_flag;
    hw_trap[0] |=> trap_flag_reg[2];
  endproperty
  a_trap_flag: assert property (p_trap_flag)
    else $error("Trap event did not set its flag.");

  property p_trap_entry;
    trap_new && !trap_active_reg |=> trap_entry && trap_active_reg;
  endproperty
  a_trap_entry: assert property (p_trap_entry)
    else $error("Trap was not entered at once.");

  property p_sw_req;
    wr && is_node(addr) && wdata[`N_REQ] |=> node_reg[$past(addr[6:0])][0];
  endproperty
  a_sw_req: assert property (p_sw_req)
    else $error("Written request flag was lost.");

  c_xfer: cover property (xfer_reg.valid);
  c_int: cover property (int_entry.entry);
  c_trap: cover property (trap_entry);
endmodule

// [verilog/intr_cfg.svh]
// Offsets, field positions and timing counts of the interrupt system.
//
// What this block does
// - Each node is served by either the vectored controller or transfer engine.
// - A standard service suspends the program and branches to the node vector.
// - A transfer service steals only one cycle from the CPU.
// - A transfer moves a byte or word, then bumps source, destination or both.
// - Each transfer decrements the channel counter unless continuous mode is set.
// - A transfer with counter at zero becomes a standard interrupt instead.
// - Eight independent transfer channels exist.
// - Interrupt response is 7 clocks with jump cache, 11 without.
// - 96 nodes, each with request flag, enable flag and priority field.
// - Source select registers choose the source of each shared node.
// - The router has 4 trigger inputs, a routing matrix, 4 gating outputs.
// - Each router input detects rising, falling or either edge.
// - Each gating output passes events on pattern match or on miss.
// - A hardware trap branches at once to its own vector.
// - Each hardware trap sets its own bit in the trap flag register.
// - A trap interrupts anything except a higher priority trap service.
// - Interrupts and transfers do not preempt a running trap service.
// - Three service request pins raise two system request traps.
// - A software trap with a number invokes the service of that number; the code sets the request flag of node sw_trap_num, below 96 only.
// - Writing a node request flag raises a request like hardware does.
`ifndef INTR_CFG_SVH
`define INTR_CFG_SVH
`define A_NODE_LAST 8'h5F
`define A_CNT 8'h60
`define A_SRC 8'h68
`define A_DST 8'h70
`define A_TRAP 8'h78
`define A_SHSEL 8'h79
`define A_RT_EDGE 8'h7A
`define A_RT_GATE 8'h7B
`define A_STAT 8'h7C
`define N_REQ 0
`define N_EN 1
`define N_PRI 5:2
`define N_XFER 6
`define N_CH 9:7
`define C_CNT 7:0
`define C_CONT 8
`define C_WORD 9
`define C_INCS 10
`define C_INCD 11
`define G_PAT 11:8
`define G_MISS 12
`define TRAP_SR0 0
`define TRAP_SR1 1
`define RESP_CACHED 7
`define RESP_PLAIN 11
`define RESET_NODE 10'h000
`endif

// [verilog/intr_pkg.sv]
// Types shared by the interrupt system and its surroundings.
package intr_pkg;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_XFER = 2'b10
  } state_type;
  typedef struct packed {
    logic valid;
    logic word;
    logic [2:0] chan;
    logic [15:0] src;
    logic [15:0] dst;
  } xfer_type;
  typedef struct packed {
    logic entry;
    logic [6:0] vector;
  } entry_type;
endpackage

// [tb/cpu_partner.sv]
// Model of the CPU core and peripheral request sources at the far side.
`timescale 1ns/10ps
module cpu_partner #(
  parameter int DONE_DELAY = 20
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic trap_entry,
  output logic [87:0] periph_req,
  output logic trap_done
);
  int left_reg;

  initial periph_req = 88'h0;

  // Peripheral sources raise their request lines for one clock.
  task automatic pulse(input logic [87:0] mask);
    @(posedge ref_clk);
    periph_req <= mask;
    @(posedge ref_clk);
    periph_req <= 88'h0;
  endtask

  // The trap handler runs a while before returning, so that requests
  // arriving meanwhile must wait behind it.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      left_reg <= 0;
      trap_done <= 1'b0;
    end else begin
      trap_done <= (left_reg == 1);
      if (trap_entry) begin
        left_reg <= DONE_DELAY;
      end else if (left_reg > 0) begin
        left_reg <= left_reg - 1;
      end
    end
  end
endmodule

// [tb/interrupt_and_event_transfer_system_tb.sv]
// Testbench for nodes, transfer channels, router and trap handling.
`timescale 1ns/10ps
module interrupt_and_event_transfer_system_tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [87:0] periph_req;
  logic [7:0] shared_src = 8'h00;
  logic [3:0] router_in = 4'h0;
  logic [5:0] hw_trap = 6'h00;
  logic [2:0] sreq_pins = 3'h0;
  logic sw_trap = 1'b0;
  logic [6:0] sw_trap_num = 7'h00;
  logic jump_cache = 1'b1;
  logic trap_done;
  logic trap_entry;
  logic [2:0] trap_number;
  intr_pkg::entry_type int_entry;
  intr_pkg::xfer_type xfer;
  intr_pkg::xfer_type xs;
  logic got;
  int n1;
  int n2;
  int err_count = 0;
  int num_checks = 0;

  always #2 ref_clk = ~ref_clk;

  interrupt_and_event_transfer_system interrupt_and_event_transfer_system_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .periph_req(periph_req), .shared_src(shared_src),
    .router_in(router_in), .hw_trap(hw_trap),
    .service_request_pins(sreq_pins), .sw_trap(sw_trap),
    .sw_trap_num(sw_trap_num), .jump_cache(jump_cache),
    .trap_done(trap_done), .int_entry(int_entry), .xfer(xfer),
    .trap_entry(trap_entry), .trap_number(trap_number)
  );

  cpu_partner cpu_partner_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .trap_entry(trap_entry),
    .periph_req(periph_req), .trap_done(trap_done)
  );

  // Every comparison is counted; case inequality keeps unknowns failing.
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // A gap cycle follows each strobe so that back-to-back calls never
  // assign a strobe twice in one time step.
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // Read data are sampled in the single cycle after the strobe.
  task automatic rd_chk(input string name, input logic [7:0] a,
                        input logic [15:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(posedge ref_clk);
    chk(name, exp, rdata);
  endtask

  // Counts edges until the one-cycle entry pulse, bounded by lim.
  task automatic wait_entry(input int lim, output logic g, output int n);
    g = 1'b0;
    n = 0;
    while (!g && n < lim) begin
      @(posedge ref_clk);
      n++;
      g = (int_entry.entry === 1'b1);
    end
  endtask

  task automatic wait_xfer(output logic g);
    int n;
    g = 1'b0;
    n = 0;
    while (!g && n < 12) begin
      @(posedge ref_clk);
      n++;
      xs = xfer;
      g = (xs.valid === 1'b1);
    end
  endtask

  task automatic wait_trap(output logic g);
    int n;
    g = 1'b0;
    n = 0;
    while (!g && n < 12) begin
      @(posedge ref_clk);
      n++;
      g = (trap_entry === 1'b1);
    end
  endtask

  task automatic t_reset;
    rd_chk("node0", 8'h00, 16'h0000);
    rd_chk("chan0", 8'h60, 16'h0000);
    rd_chk("flags", 8'h78, 16'h0000);
    rd_chk("unmapped", 8'hA0, 16'h0000);
    rd_chk("status", 8'h7C, 16'h0000);
  endtask

  // Software-set request flag; cached and plain answers differ by four.
  task automatic t_latency;
    wr_reg(8'h05, 16'h000F);
    wait_entry(40, got, n1);
    chk("vector", 32'h5, int_entry.vector);
    jump_cache <= 1'b0;
    wr_reg(8'h05, 16'h000F);
    wait_entry(40, got, n2);
    chk("latency gap", 32'h4, n2 - n1);
    jump_cache <= 1'b1;
    // A low enable must hold the pending grant and stretch the answer.
    wr_reg(8'h05, 16'h000F);
    ce <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ce <= 1'b1;
    wait_entry(40, got, n2);
    chk("ce freeze", 32'h8, n2);
  endtask

  task automatic t_prio;
    wr_reg(8'h0A, 16'h000A);
    wr_reg(8'h14, 16'h0026);
    cpu_partner_inst.pulse((88'h1 << 10) | (88'h1 << 20));
    wait_entry(40, got, n1);
    chk("first", 32'h14, int_entry.vector);
    wait_entry(40, got, n1);
    chk("second", 32'h0A, int_entry.vector);
  endtask

  // Word channel counting down to zero, which then calls the vector.
  task automatic t_xfer;
    wr_reg(8'h61, 16'h0602);
    wr_reg(8'h69, 16'h0100);
    wr_reg(8'h71, 16'h0200);
    wr_reg(8'h1E, 16'h00C6);
    cpu_partner_inst.pulse(88'h1 << 30);
    wait_xfer(got);
    chk("xfer1", {1'b1, 3'h1, 16'h0100, 8'h02},
        {xs.word, xs.chan, xs.src, xs.dst[15:8]});
    cpu_partner_inst.pulse(88'h1 << 30);
    wait_xfer(got);
    chk("xfer2 src", 32'h0102, xs.src);
    rd_chk("count", 8'h61, 16'h0600);
    rd_chk("dst kept", 8'h71, 16'h0200);
    cpu_partner_inst.pulse(88'h1 << 30);
    wait_entry(30, got, n1);
    chk("zero vector", {1'b1, 7'h1E}, {got, int_entry.vector});
  endtask

  // Continuous byte channel 7 keeps its count and bumps the destination.
  task automatic t_cont;
    wr_reg(8'h67, 16'h0903);
    wr_reg(8'h6F, 16'h0010);
    wr_reg(8'h77, 16'h0020);
    wr_reg(8'h1F, 16'h03C2);
    cpu_partner_inst.pulse(88'h1 << 31);
    wait_xfer(got);
    cpu_partner_inst.pulse(88'h1 << 31);
    wait_xfer(got);
    chk("cont", {1'b0, 3'h7, 16'h0010, 8'h21},
        {xs.word, xs.chan, xs.src, xs.dst[7:0]});
    rd_chk("cont count", 8'h67, 16'h0903);
  endtask

  // Each trap source sets its flag, pins 1 and 2 a shared one; a request waits behind a trap.
  task automatic t_trap;
    logic [2:0] num;
    for (int i = 0; i < 9; i++) begin
      num = (i < 3) ? ((i == 0) ? 3'h0 : 3'h1) : 3'(i - 1);
      @(posedge ref_clk);
      if (i < 3) sreq_pins <= 3'(1 << i);
      else hw_trap <= 6'(1 << (i - 3));
      @(posedge ref_clk);
      hw_trap <= 6'h00;
      wait_trap(got);
      chk("trap number", {1'b1, num}, {got, trap_number});
      if (i == 3) begin
        wr_reg(8'h28, 16'h0003);
        wait_entry(60, got, n1);
        chk("held off", 32'h1, 32'(n1 > 14));
      end
      sreq_pins <= 3'h0;
      repeat (25) @(posedge ref_clk);
      rd_chk("flag", 8'h78, 16'(1 << num));
      wr_reg(8'h78, 16'(1 << num));
    end
    rd_chk("cleared", 8'h78, 16'h0000);
  endtask

  task automatic t_sw;
    @(posedge ref_clk);
    sw_trap <= 1'b1;
    sw_trap_num <= 7'h32;
    @(posedge ref_clk);
    sw_trap <= 1'b0;
    rd_chk("sw flag", 8'h32, 16'h0001);
  endtask

  // Rising edge passes the gate on a pattern miss; falling is ignored.
  task automatic t_router;
    wr_reg(8'h7A, 16'h0001);
    wr_reg(8'h7B, 16'h1000);
    wr_reg(8'h58, 16'h0002);
    router_in <= 4'h1;
    wait_entry(30, got, n1);
    chk("rise", {1'b1, 7'h58}, {got, int_entry.vector});
    router_in <= 4'h0;
    wait_entry(30, got, n1);
    chk("fall", 32'h0, got);
    // Falling edge mode, and the gate now passes on a pattern match.
    wr_reg(8'h7A, 16'h0002);
    wr_reg(8'h7B, 16'h0000);
    router_in <= 4'h1;
    wait_entry(30, got, n1);
    chk("rise ignored", 32'h0, got);
    router_in <= 4'h0;
    wait_entry(30, got, n1);
    chk("fall match", {1'b1, 7'h58}, {got, int_entry.vector});
    wr_reg(8'h79, 16'h0001);
    wr_reg(8'h5C, 16'h0002);
    shared_src <= 8'h02;
    @(posedge ref_clk);
    shared_src <= 8'h00;
    wait_entry(30, got, n1);
    chk("shared", {1'b1, 7'h5C}, {got, int_entry.vector});
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles; this cuts off a hang.
  initial begin
    #40000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_latency();
    t_prio();
    t_xfer();
    t_cont();
    t_trap();
    t_sw();
    t_router();
    tally_and_finish();
  end
endmodule
